/* File: script_irq_vector_and_var_alu.sv */
`timescale 1ns/1ps
// Overview of operation
// - Opcode 37 defines handler address: type is irq number, value is address.
// - Direct-mode replies to the three commands carry status 100, value zero.
// - Opcode 38 ends the handler; flow resumes where it was interrupted.
// - Handler return restores accumulator, X register, flags and program counter.
// - Vector define and handler return act only in standalone program execution.
// - Reply order: host, target, status 64h, instruction, value MSB first, checksum.
// - Opcode 40: type selects op, bank indexes var one, value indexes var two.
// - Result goes into the first variable; second unchanged except on exchange.
// - Operands come straight from user variables, never through accumulator or X.
// - Codes 0..4: add, subtract, multiply, divide, remainder of var one by two.
// - Codes 5..7: bitwise AND, OR, XOR stored into the first variable.
// - Code 8 stores inverse of var two; code 9 copies var two into one.
// - Code 10 exchanges both variables, writing both.
// - Code 11 compares var one with two, only updating comparison flags.
// - Defining a vector again for the same number replaces the old one.
// - Interrupt 255 enable gates all interrupt processing besides per-source enables.
module script_irq_vector_and_var_alu (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_direct,
  input wire script_pkg::cmd_t cmd,
  input wire logic irq_req,
  input wire logic [7:0] irq_num,
  input wire logic irq_src_en,
  input wire logic irq_global_en,
  input wire script_pkg::cpu_t cpu_now,
  input wire logic [7:0] var_rd_idx,
  output logic reply_valid,
  output script_pkg::reply_t reply,
  output logic jump_valid,
  output logic [31:0] jump_addr,
  output logic irq_ack,
  output logic in_handler,
  output logic restore_valid,
  output script_pkg::cpu_t restore,
  output script_pkg::flags_t cmp_flags,
  output logic [31:0] var_rd_data
);
  import script_pkg::*;

  logic [31:0] uvar_ff [VAR_COUNT];
  logic [31:0] vec_addr_ff [VEC_COUNT];
  logic [VEC_COUNT-1:0] vec_def_ff;
  exec_state_t state_ff;
  exec_state_t nxt_state;
  logic in_handler_ff;
  cpu_t saved_cpu_ff;
  flags_t saved_flags_ff;
  flags_t flags_ff;
  flags_t nxt_flags;
  logic reply_valid_ff;
  reply_t reply_ff;
  logic jump_valid_ff;
  logic [31:0] jump_addr_ff;
  logic irq_ack_ff;
  logic restore_valid_ff;
  cpu_t restore_ff;
  logic [31:0] var_rd_ff;

  // Command decode
  wire logic is_vec = cmd_valid && (cmd.opcode == OPC_VEC_DEFINE);
  wire logic is_ret = cmd_valid && (cmd.opcode == OPC_HANDLER_RET);
  wire logic is_arith = cmd_valid && (cmd.opcode == OPC_TWO_VAR);
  wire logic standalone = !cmd_direct;
  wire logic vec_do = is_vec && standalone;
  wire logic ret_do = is_ret && standalone && (state_ff == ST_HANDLER);
  wire logic needs_reply = cmd_direct && (is_vec || is_ret || is_arith);

  // Operand fetch straight from variable storage
  wire logic [7:0] idx_a = cmd.bank;
  wire logic [7:0] idx_b = cmd.value[7:0];
  wire logic [31:0] var_a = uvar_ff[idx_a];
  wire logic [31:0] var_b = uvar_ff[idx_b];
  wire logic signed [31:0] sa = var_a;
  wire logic signed [31:0] sb = var_b;
  wire logic b_zero = (var_b == WORD_RST);
  wire logic signed [63:0] prod_full = sa * sb;
  wire logic signed [31:0] quot = b_zero ? sa : (sa / sb);
  wire logic signed [31:0] rem = b_zero ? sa : (sa % sb);

  logic [31:0] alu_res;
  logic alu_wr;
  always_comb begin
    alu_res = var_a;
    alu_wr = 1'b1;
    case (cmd.typ)
      OP_ADD: alu_res = var_a + var_b;
      OP_SUB: alu_res = var_a - var_b;
      OP_PRODUCT: alu_res = prod_full[31:0];
      OP_DIV: alu_res = quot;
      OP_REMAINDER: alu_res = rem;
      OP_AND: alu_res = var_a & var_b;
      OP_OR: alu_res = var_a | var_b;
      OP_XOR: alu_res = var_a ^ var_b;
      OP_NOT: alu_res = ~var_b;
      OP_LOAD: alu_res = var_b;
      OP_SWAP: alu_res = var_b;
      OP_COMP: alu_wr = 1'b0;
      default: alu_wr = 1'b0;
    endcase
  end

  wire logic wr1_en = is_arith && alu_wr;
  wire logic wr2_en = is_arith && (cmd.typ == OP_SWAP);
  wire logic cmp_do = is_arith && (cmd.typ == OP_COMP);

  // Interrupt acceptance
  wire logic irq_ok = irq_req && irq_src_en && irq_global_en;
  wire logic irq_take = irq_ok && vec_def_ff[irq_num] && (state_ff == ST_MAIN) && !cmd_valid;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_MAIN: if (irq_take) begin
        nxt_state = ST_HANDLER;
      end
      ST_HANDLER: if (ret_do) begin
        nxt_state = ST_MAIN;
      end
      default: nxt_state = ST_MAIN;
    endcase
  end

  always_comb begin
    nxt_flags = flags_ff;
    if (ret_do) begin
      nxt_flags = saved_flags_ff;
    end else if (cmp_do) begin
      nxt_flags.zero = (var_a == var_b);
      nxt_flags.less = (sa < sb);
    end
  end

  // Reply frame, value field zero
  wire logic [7:0] reply_instr = cmd.opcode;
  wire logic [7:0] reply_sum = cmd.host_addr + cmd.target_addr + STATUS_OK + reply_instr;
  reply_t nxt_reply;
  assign nxt_reply = '{host_addr: cmd.host_addr, target_addr: cmd.target_addr,
                       status: STATUS_OK, instr: reply_instr,
                       value: WORD_RST, cksum: reply_sum};

  // Per-entry variable storage and vector table
  genvar gi;
  generate
    for (gi = 0; gi < VAR_COUNT; gi++) begin : g_entry
      wire logic hit1 = wr1_en && (idx_a == 8'(gi));
      wire logic hit2 = wr2_en && (idx_b == 8'(gi));
      wire logic vhit = vec_do && (cmd.typ == 8'(gi));
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          uvar_ff[gi] <= WORD_RST;
          vec_addr_ff[gi] <= WORD_RST;
          vec_def_ff[gi] <= 1'b0;
        end else begin
          if (hit1) begin
            uvar_ff[gi] <= alu_res;
          end else if (hit2) begin
            uvar_ff[gi] <= var_a;
          end
          if (vhit) begin
            vec_addr_ff[gi] <= cmd.value;
            vec_def_ff[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_MAIN;
      in_handler_ff <= 1'b0;
      flags_ff <= '0;
      saved_flags_ff <= '0;
      saved_cpu_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      in_handler_ff <= (nxt_state == ST_HANDLER);
      flags_ff <= nxt_flags;
      if (irq_take) begin
        saved_cpu_ff <= cpu_now;
        saved_flags_ff <= flags_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reply_valid_ff <= 1'b0;
      reply_ff <= '0;
    end else begin
      reply_valid_ff <= needs_reply;
      if (needs_reply) begin
        reply_ff <= nxt_reply;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      jump_valid_ff <= 1'b0;
      jump_addr_ff <= WORD_RST;
      irq_ack_ff <= 1'b0;
    end else begin
      jump_valid_ff <= irq_take;
      irq_ack_ff <= irq_take;
      if (irq_take) begin
        jump_addr_ff <= vec_addr_ff[irq_num];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      restore_valid_ff <= 1'b0;
      restore_ff <= '0;
      var_rd_ff <= WORD_RST;
    end else begin
      restore_valid_ff <= ret_do;
      if (ret_do) begin
        restore_ff <= saved_cpu_ff;
      end
      var_rd_ff <= uvar_ff[var_rd_idx];
    end
  end

  assign reply_valid = reply_valid_ff;
  assign reply = reply_ff;
  assign jump_valid = jump_valid_ff;
  assign jump_addr = jump_addr_ff;
  assign irq_ack = irq_ack_ff;
  assign in_handler = in_handler_ff;
  assign restore_valid = restore_valid_ff;
  assign restore = restore_ff;
  assign cmp_flags = flags_ff;
  assign var_rd_data = var_rd_ff;

  // Checks
  AST_VEC_STORE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    vec_do |=> vec_def_ff[$past(cmd.typ)] && vec_addr_ff[$past(cmd.typ)] == $past(cmd.value))
    else $error("vector entry not stored");
  AST_REPLY_OK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    needs_reply |=> reply_valid && reply.status == 8'h64 && reply.value == 32'h0)
    else $error("direct reply missing or wrong status");
  AST_RET_RESUME: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ret_do |=> restore_valid && !in_handler)
    else $error("handler return did not resume main flow");
  AST_RET_RESTORE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ret_do |=> restore_valid && restore == $past(saved_cpu_ff))
    else $error("saved state not restored");
  AST_SAVE_ENTRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_take |=> saved_cpu_ff == $past(cpu_now) && in_handler)
    else $error("machine state not saved on entry");
  AST_DIRECT_NO_VEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (is_vec || is_ret) && cmd_direct |=> $stable(vec_def_ff) && !restore_valid)
    else $error("direct vector or return command took effect");
  AST_REPLY_SUM: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reply_valid |-> reply.cksum == 8'(reply.host_addr + reply.target_addr + reply.status + reply.instr))
    else $error("reply checksum wrong");
  AST_ADD_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h00 |=> uvar_ff[$past(idx_a)] == 32'($past(var_a) + $past(var_b)))
    else $error("addition result wrong");
  AST_SUB_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h01 |=> uvar_ff[$past(idx_a)] == 32'($past(var_a) - $past(var_b)))
    else $error("subtraction result wrong");
  AST_SECOND_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ != 8'h0a && idx_a != idx_b |=> uvar_ff[$past(idx_b)] == $past(var_b))
    else $error("second variable changed");
  AST_SWAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h0a |=> uvar_ff[$past(idx_a)] == $past(var_b)
      && uvar_ff[$past(idx_b)] == $past(var_a))
    else $error("exchange incomplete");
  AST_COMP_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_do |=> cmp_flags.zero == ($past(var_a) == $past(var_b)) && uvar_ff[$past(idx_a)] == $past(var_a))
    else $error("compare wrong or stored a result");
  AST_XOR_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h07 |=> uvar_ff[$past(idx_a)] == ($past(var_a) ^ $past(var_b)))
    else $error("xor result wrong");
  AST_NOT_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h08 |=> uvar_ff[$past(idx_a)] == ~$past(var_b))
    else $error("inverse result wrong");
  AST_LOAD_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_arith && cmd.typ == 8'h09 |=> uvar_ff[$past(idx_a)] == $past(var_b))
    else $error("copy result wrong");
  AST_GLOBAL_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !irq_global_en |=> !jump_valid)
    else $error("interrupt taken while globally disabled");
  AST_NO_NEST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_handler && !ret_do |=> !jump_valid)
    else $error("nested interrupt taken");
  AST_JUMP_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_take |=> jump_valid && irq_ack && jump_addr == $past(vec_addr_ff[irq_num]))
    else $error("jump to wrong vector");
  AST_FLAGS_BACK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ret_do |=> cmp_flags == $past(saved_flags_ff))
    else $error("flags not restored");
  AST_FLAGS_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cmp_do && !ret_do |=> $stable(cmp_flags))
    else $error("flags changed without compare or return");

endmodule

/* File: script_pkg.sv */
package script_pkg;

  localparam logic [7:0] OPC_VEC_DEFINE = 8'h25;
  localparam logic [7:0] OPC_HANDLER_RET = 8'h26;
  localparam logic [7:0] OPC_TWO_VAR = 8'h28;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] IRQ_GLOBAL_NUM = 8'hff;

  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_PRODUCT = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  localparam logic [7:0] OP_REMAINDER = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] OP_SWAP = 8'h0a;
  localparam logic [7:0] OP_COMP = 8'h0b;

  localparam int VAR_COUNT = 256;
  localparam int VEC_COUNT = 256;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef struct packed {
    logic [7:0] host_addr;
    logic [7:0] target_addr;
    logic [7:0] opcode;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_t;

  typedef struct packed {
    logic [7:0] host_addr;
    logic [7:0] target_addr;
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
    logic [7:0] cksum;
  } reply_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [31:0] pc;
  } cpu_t;

  typedef struct packed {
    logic zero;
    logic less;
  } flags_t;

  typedef enum logic [1:0] {
    ST_MAIN = 2'b00,
    ST_HANDLER = 2'b01
  } exec_state_t;

endpackage

/* File: host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic cmd_direct,
  output script_pkg::cmd_t cmd
);
  import script_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_direct = 1'b0;
    cmd = '0;
  end
  // One command per cycle, held across the sampling edge
  task automatic issue(input logic d, input logic [7:0] opc, typ, bank, input logic [31:0] val);
    @(negedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_direct <= d;
    cmd <= {8'h02, 8'h01, opc, typ, bank, val};
  endtask
  // Released fields must not keep their last value
  task automatic idle();
    @(negedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
  endtask
endmodule

/* File: test_script_irq_vector_and_var_alu.sv */
`timescale 1ns/1ps
module test_script_irq_vector_and_var_alu;
  import script_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_direct, reply_valid, jump_valid, irq_ack, in_handler, restore_valid;
  logic irq_req = 1'b0;
  logic irq_src_en = 1'b1;
  logic irq_global_en = 1'b0;
  logic [7:0] irq_num = 8'h00;
  logic [7:0] var_rd_idx = 8'h00;
  logic [31:0] jump_addr, var_rd_data;
  cpu_t cpu_now = '0;
  cpu_t restore, saved;
  cmd_t cmd;
  reply_t reply;
  flags_t cmp_flags, fl, sfl;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] m [256];
  logic [31:0] rnd = 32'h29a0e9e8;
  reply_t exq [$];

  always #12.5 ref_clk = ~ref_clk;

  host_model host_model_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_direct(cmd_direct), .cmd(cmd));
  script_irq_vector_and_var_alu script_irq_vector_and_var_alu_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_direct(cmd_direct), .cmd(cmd), .irq_req(irq_req), .irq_num(irq_num),
    .irq_src_en(irq_src_en), .irq_global_en(irq_global_en), .cpu_now(cpu_now), .var_rd_idx(var_rd_idx),
    .reply_valid(reply_valid), .reply(reply), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .irq_ack(irq_ack), .in_handler(in_handler), .restore_valid(restore_valid), .restore(restore),
    .cmp_flags(cmp_flags), .var_rd_data(var_rd_data));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Drive one command and advance the reference model
  task automatic op(input logic d, input logic [7:0] opc, typ, bank, input logic [31:0] val);
    logic [31:0] a, b, r;
    host_model_i.issue(d, opc, typ, bank, val);
    a = m[bank];
    b = m[val[7:0]];
    r = a;
    if (d && opc inside {OPC_VEC_DEFINE, OPC_HANDLER_RET, OPC_TWO_VAR}) begin
      exq.push_back({8'h02, 8'h01, STATUS_OK, opc, 32'h0, 8'h03 + STATUS_OK + opc});
    end
    if (opc == OPC_TWO_VAR) begin
      case (typ)
        OP_ADD: r = a + b;
        OP_SUB: r = a - b;
        OP_PRODUCT: r = a * b;
        OP_DIV: r = (b == 0) ? a : 32'($signed(a) / $signed(b));
        OP_REMAINDER: r = (b == 0) ? a : 32'($signed(a) % $signed(b));
        OP_AND: r = a & b;
        OP_OR: r = a | b;
        OP_XOR: r = a ^ b;
        OP_NOT: r = ~b;
        OP_LOAD: r = b;
        OP_SWAP: begin
          m[val[7:0]] = a;
          r = b;
        end
        OP_COMP: fl = {a == b, $signed(a) < $signed(b)};
        default: ;
      endcase
      m[bank] = r;
      if (typ == OP_COMP) begin
        host_model_i.idle();
        check(cmp_flags, fl);
      end
    end
  endtask

  task automatic no_ack();
    repeat (5) begin
      @(negedge ref_clk);
      check({irq_ack, jump_valid}, 2'b00);
    end
  endtask

  always @(negedge ref_clk) begin
    if (reply_valid === 1'b1) begin
      if (exq.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        check(reply, exq.pop_front());
      end
    end
  end

  initial begin
    foreach (m[i]) m[i] = 32'h0;
    fl = '0;
    repeat (3) @(negedge ref_clk);
    check({reply_valid, jump_valid, irq_ack, in_handler, restore_valid}, 5'h00);
    rst_n = 1'b1;
    op(1'b0, OPC_TWO_VAR, OP_NOT, 8'h01, 32'h0);
    op(1'b0, OPC_TWO_VAR, OP_SUB, 8'h02, 32'h1);
    for (int i = 0; i < 200; i++) begin
      rnd = lfsr(rnd);
      op(rnd[12], (rnd[15:13] == 3'h0) ? 8'h27 : OPC_TWO_VAR, 8'(rnd[11:8] % 13),
         (rnd[7:4] == 4'h0) ? 8'hff : {5'h0, rnd[2:0]}, {rnd[31:8], 5'h0, rnd[18:16]});
    end
    host_model_i.idle();
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk);
      var_rd_idx = (i < 8) ? 8'(i) : 8'hff;
      @(negedge ref_clk);
      check(var_rd_data, m[var_rd_idx]);
    end
    op(1'b1, OPC_VEC_DEFINE, 8'h04, 8'h00, 32'h40);
    op(1'b0, OPC_VEC_DEFINE, 8'h03, 8'h00, 32'h50);
    op(1'b0, OPC_VEC_DEFINE, 8'h03, 8'h00, 32'h1234);
    op(1'b0, OPC_TWO_VAR, OP_COMP, 8'h01, 32'h1);
    irq_num = 8'h04;
    irq_req = 1'b1;
    irq_global_en = 1'b1;
    no_ack();
    irq_num = 8'h03;
    irq_global_en = 1'b0;
    no_ack();
    irq_src_en = 1'b0;
    irq_global_en = 1'b1;
    no_ack();
    irq_src_en = 1'b1;
    cpu_now = {rnd, ~rnd, rnd ^ 32'h5a5a5a5a};
    saved = cpu_now;
    sfl = fl;
    irq_global_en = 1'b1;
    @(negedge ref_clk);
    check({irq_ack, jump_valid, in_handler, jump_addr}, {3'b111, 32'h1234});
    cpu_now = ~cpu_now;
    no_ack();
    irq_req = 1'b0;
    op(1'b0, OPC_TWO_VAR, OP_NOT, 8'h05, 32'h6);
    op(1'b0, OPC_TWO_VAR, OP_COMP, 8'h05, 32'h6);
    op(1'b1, OPC_HANDLER_RET, 8'hff, 8'h00, 32'h0);
    host_model_i.idle();
    check({restore_valid, in_handler}, 2'b01);
    // Handler ends with its return
    op(1'b0, OPC_HANDLER_RET, 8'hff, 8'h00, 32'h0);
    host_model_i.idle();
    check({restore_valid, in_handler, restore, cmp_flags}, {2'b10, saved, sfl});
    op(1'b0, OPC_HANDLER_RET, 8'hff, 8'h00, 32'h0);
    host_model_i.idle();
    check({restore_valid, in_handler}, 2'b00);
    repeat (2) @(negedge ref_clk);
    check(exq.size(), 0);
    final_report();
  end
endmodule
